// *** core_model.sv ***
// Processor core model issuing watchdog refresh and power-mode requests
`timescale 1ns/100ps
`default_nettype none
module core_model (
  // Clock
  input wire logic core_clk,
  // Requests to the sequencer
  output logic wdog_refresh,
  output logic halt_req,
  output logic stop_req,
  output logic standby_req
);
  import sysctl_pkg::*;

  ////////////////////////////////////////////////////////////////////////////
  // Idle until the bench asks for an instruction
  initial
  begin
    wdog_refresh = 1'b0;
    {stop_req, halt_req, standby_req} = 3'h0;
  end

  // One refresh instruction: first one enables, later ones restart
  task automatic refresh();
    @(posedge core_clk);
    wdog_refresh <= 1'b1;
    @(posedge core_clk);
    wdog_refresh <= 1'b0;
  endtask : refresh

  // Idle cycle first so the pipeline is empty before suspending
  task automatic enter_mode(input logic [2:0] m);
    @(posedge core_clk);
    @(posedge core_clk);
    {stop_req, halt_req, standby_req} <= m;
    @(posedge core_clk);
    {stop_req, halt_req, standby_req} <= 3'h0;
  endtask : enter_mode

endmodule : core_model
`default_nettype wire

// *** pin_sync3.sv ***
// Three-stage synchroniser with agreement filter for an external pin
`timescale 1ns/100ps
`default_nettype none
module pin_sync3 (
  // Clock and reset
  input wire logic core_clk,
  input wire logic rst,
  // Raw pin and cleaned level
  input wire logic pin_in,
  output logic level_ff
);
  logic s1_ff;
  logic s2_ff;
  logic s3_ff;

  // First stage feeds only the second, against metastability
  always_ff @(posedge core_clk or posedge rst)
  begin
    if (rst)
    begin
      s1_ff <= 1'b0;
      s2_ff <= 1'b0;
      s3_ff <= 1'b0;
    end
    else
    begin
      s1_ff <= pin_in;
      s2_ff <= s1_ff;
      s3_ff <= s2_ff;
    end
  end

  // Level moves only once stages two and three agree
  always_ff @(posedge core_clk or posedge rst)
  begin
    if (rst)
      level_ff <= 1'b0;
    else if (s2_ff == s3_ff)
      level_ff <= s3_ff;
  end
endmodule : pin_sync3
`default_nettype wire

// *** reset_watchdog_power_modes_tb.sv ***
// Self-checking bench for the reset, watchdog and power-mode sequencer
`timescale 1ns/100ps
`default_nettype none
module reset_watchdog_power_modes_tb;
  import sysctl_pkg::*;
  // Short time-out keeps the bite near 500 cycles
  localparam int WT = 4;
  localparam int TICK = RC_DIV_CYC;
  logic core_clk, rst, perm_wdog_opt, recover_pin;
  logic wdog_refresh, halt_req, stop_req, standby_req;
  logic cpu_clk_en_ff, timer_clk_en_ff, osc_en_ff, wdog_clk_en_ff;
  logic core_hold_ff, regs_default_ff, flag_hold_ff, wdog_enabled_ff;
  logic [15:0] fetch_addr_ff;
  logic [1:0] reset_cause_ff;
  power_state_t state_ff;
  int miscompares = 0;
  int n_tests = 0;
  int seed = 5;

  ////////////////////////////////////////////////////////////////////////////
  // Design and core model
  sysctl_top #(.WDOG_TIMEOUT(WT)) DUT (.core_clk(core_clk), .rst(rst),
    .perm_wdog_opt(perm_wdog_opt), .wdog_refresh(wdog_refresh), .halt_req(halt_req),
    .stop_req(stop_req), .standby_req(standby_req), .recover_pin(recover_pin),
    .cpu_clk_en_ff(cpu_clk_en_ff), .timer_clk_en_ff(timer_clk_en_ff),
    .osc_en_ff(osc_en_ff), .wdog_clk_en_ff(wdog_clk_en_ff), .core_hold_ff(core_hold_ff),
    .regs_default_ff(regs_default_ff), .fetch_addr_ff(fetch_addr_ff),
    .flag_hold_ff(flag_hold_ff), .wdog_enabled_ff(wdog_enabled_ff),
    .reset_cause_ff(reset_cause_ff), .state_ff(state_ff));
  core_model u_core (.core_clk(core_clk), .wdog_refresh(wdog_refresh),
    .halt_req(halt_req), .stop_req(stop_req), .standby_req(standby_req));

  // Clock and time-zero values
  initial
  begin
    core_clk = 1'b0;
    rst = 1'b1;
    perm_wdog_opt = 1'b0;
    recover_pin = 1'b0;
  end
  always #(CLK_PERIOD_NS / 2) core_clk = ~core_clk;

  ////////////////////////////////////////////////////////////////////////////
  // Expectations: gate order is cpu, timer, oscillator, watchdog
  function automatic logic [3:0] exp_gates(power_state_t s, logic en);
    case (s)
      ST_RUN: return {3'h7, en};
      ST_HALT, ST_RESET, ST_RECOVER: return 4'h6;
      default: return 4'h0;
    endcase
  endfunction : exp_gates

  // Stop wins over halt, halt over standby
  function automatic power_state_t exp_mode(logic [2:0] m);
    if (m[2])
      return ST_STOP;
    if (m[1])
      return ST_HALT;
    return ST_STANDBY;
  endfunction : exp_mode

  task automatic check(input logic [15:0] seen, input logic [15:0] exp, input string what);
    n_tests++;
    if (seen !== exp)
    begin
      miscompares++;
      $display("wrong value at %0t: %s seen %h expected %h", $time, what, seen, exp);
    end
  endtask : check

  task automatic check_gates(input power_state_t s, input logic en);
    check({12'h0, cpu_clk_en_ff, timer_clk_en_ff, osc_en_ff, wdog_clk_en_ff},
      {12'h0, exp_gates(s, en)}, "gates");
  endtask : check_gates

  // Bounded wait; returns cycles spent
  task automatic wait_state(input power_state_t s, input int lim, output int n);
    n = 0;
    // Step off the edge so the state is settled
    #1;
    while (state_ff !== s && n < lim)
    begin
      @(posedge core_clk);
      #1;
      n++;
    end
    check(16'(state_ff), 16'(s), "state reached");
  endtask : wait_state

  task automatic do_reset(input logic perm);
    @(posedge core_clk);
    rst <= 1'b1;
    perm_wdog_opt <= perm;
    repeat (16) @(posedge core_clk);
    #1;
    check(16'(state_ff), 16'(ST_RESET), "reset state");
    check({14'h0, core_hold_ff, regs_default_ff}, 16'h0003, "reset hold");
    check({14'h0, reset_cause_ff}, 16'(CAUSE_POR), "power-on cause");
    check(16'(wdog_enabled_ff), 16'h0000, "enable cleared");
    @(posedge core_clk);
    rst <= 1'b0;
    repeat (7) @(posedge core_clk);
    #1 check(16'(state_ff), 16'(ST_RESET), "hold length");
    @(posedge core_clk);
    #1 check(16'(state_ff), 16'(ST_RUN), "run after hold");
    check(fetch_addr_ff, RESET_VECTOR, "fetch address");
    check({14'h0, core_hold_ff, regs_default_ff}, 16'h0000, "released");
    $display("test reset done");
  endtask : do_reset

  // Sleep far past a bite, then wake through the recovery pin
  task automatic wake(input power_state_t s);
    int n;
    repeat (1000) @(posedge core_clk);
    #1 check(16'(state_ff), 16'(s), "no bite asleep");
    @(posedge core_clk);
    recover_pin <= 1'b1;
    repeat (6) @(posedge core_clk);
    recover_pin <= 1'b0;
    wait_state(ST_RECOVER, 20, n);
    check({14'h0, core_hold_ff, regs_default_ff}, 16'h0002, "registers kept");
    check_gates(ST_RECOVER, 1'b0);
    wait_state(ST_RUN, 20, n);
    check(16'(wdog_enabled_ff), 16'h0001, "still enabled");
    check_gates(ST_RUN, 1'b1);
  endtask : wake

  task automatic end_of_test();
    $display("comparisons %0d, mismatches %0d", n_tests, miscompares);
    if (miscompares == 0 && n_tests > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask : end_of_test

  ////////////////////////////////////////////////////////////////////////////
  // Main sequence
  initial
  begin
    int n;
    power_state_t s;
    do_reset(1'b0);
    repeat (700) @(posedge core_clk);
    #1 check(16'(state_ff), 16'(ST_RUN), "idle before refresh");
    check_gates(ST_RUN, 1'b0);
    u_core.refresh();
    #1 check({14'h0, flag_hold_ff, wdog_enabled_ff}, 16'h0003, "first refresh");
    @(posedge core_clk);
    #1 check(16'(flag_hold_ff), 16'h0000, "flag hold one cycle");
    // Random spacing, always inside the time-out
    repeat (8)
    begin
      repeat ($unsigned($random(seed)) % 300 + 1) @(posedge core_clk);
      u_core.refresh();
    end
    #1 check(16'(state_ff), 16'(ST_RUN), "refreshed, no bite");
    $display("test refresh done");
    // Every request combination, and a refused request while asleep
    for (int i = 1; i < 8; i++)
    begin
      u_core.refresh();
      u_core.enter_mode(3'(i));
      s = exp_mode(3'(i));
      #1 check(16'(state_ff), 16'(s), "mode entered");
      check_gates(s, 1'b1);
      u_core.enter_mode(3'h4);
      #1 check(16'(state_ff), 16'(s), "request refused");
      wake(s);
    end
    $display("test modes done");
    // Bite with no refresh
    u_core.refresh();
    wait_state(ST_RESET, 1000, n);
    check(16'(n >= (WT - 1) * TICK && n <= WT * TICK + 8), 16'h0001, "bite time");
    check({14'h0, core_hold_ff, regs_default_ff}, 16'h0003, "bite defaults");
    check(16'(wdog_enabled_ff), 16'h0000, "bite clears enable");
    wait_state(ST_RUN, 20, n);
    check({14'h0, reset_cause_ff}, 16'(CAUSE_WDOG), "watchdog cause");
    check(fetch_addr_ff, RESET_VECTOR, "fetch after bite");
    $display("test bite done");
    // Mid-run reset with the permanent option
    do_reset(1'b1);
    check(16'(wdog_enabled_ff), 16'h0001, "runs from power-up");
    wait_state(ST_RESET, 1000, n);
    check({14'h0, reset_cause_ff}, 16'(CAUSE_WDOG), "bite unrefreshed");
    wait_state(ST_RUN, 20, n);
    check(16'(wdog_enabled_ff), 16'h0001, "re-enabled");
    $display("test permanent done");
    end_of_test();
  end

  // Hang guard, well beyond the expected run length
  initial
  begin
    #(50000 * CLK_PERIOD_NS);
    miscompares++;
    $display("wrong value at %0t: run timed out", $time);
    end_of_test();
  end

endmodule : reset_watchdog_power_modes_tb
`default_nettype wire

// *** sysctl_pkg.sv ***
// Shared constants and types for the reset and power-mode sequencer
package sysctl_pkg;

  // Operating and restart states
  typedef enum logic [2:0] {
    ST_RESET,
    ST_RECOVER,
    ST_RUN,
    ST_HALT,
    ST_STOP,
    ST_STANDBY
  } power_state_t;

  // First fetch address after any restart
  localparam logic [15:0] RESET_VECTOR = 16'h000C;

  // Core clock period
  localparam int CLK_PERIOD_NS = 8;

  // Least time the core is held in restart
  localparam int RESET_HOLD_NS = 64;
  localparam int RESET_HOLD_CYC = (RESET_HOLD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int HOLD_W = 4;

  // Watchdog RC oscillator period, modelled as a tick
  localparam int RC_PERIOD_NS = 1000;
  localparam int RC_DIV_CYC = RC_PERIOD_NS / CLK_PERIOD_NS;
  localparam int RC_W = 8;

  // Watchdog time-out in RC cycles
  localparam int WDOG_TIMEOUT_RC = 4096;

  // Reset cause codes
  localparam logic [1:0] CAUSE_POR = 2'h1;
  localparam logic [1:0] CAUSE_WDOG = 2'h2;

  // Gate vector bit positions
  localparam int GATE_CPU = 3;
  localparam int GATE_TIMER = 2;
  localparam int GATE_OSC = 1;
  localparam int GATE_WDOG = 0;

  // Clock gates per state: cpu, timer, oscillator, watchdog
  function automatic logic [3:0] mode_gates(power_state_t s);
    logic [3:0] g;
    g = 4'h0;
    case (s)
      ST_RUN: g = 4'hF;
      ST_HALT: g = 4'h6;
      ST_RESET, ST_RECOVER: g = 4'h6;
      default: g = 4'h0;
    endcase
    return g;
  endfunction : mode_gates

endpackage : sysctl_pkg

// *** sysctl_top.sv ***
// Reset, watchdog and power-mode sequencer for the processor core
// Behaviour
// - Power-on or run-mode bite loads register defaults
// - Recovery from halt or stop keeps registers
// - No reset touches general-purpose registers
// - Restart fetch begins at address 000C
// - Watchdog bite acts like power-on reset
// - Permanent option runs watchdog from power-up
// - Otherwise first refresh enables, later ones restart
// - Enabled watchdog cannot be disabled except reset
// - Refresh leaves zero, sign, overflow flags alone
// - Watchdog stopped in halt and stop
// - Watchdog runs from RC tick, fixed period
// - Run plus halt, stop, standby modes
// - Clock gates follow the operating mode
`timescale 1ns/100ps
`default_nettype none
module sysctl_top #(
  parameter int WDOG_TIMEOUT = sysctl_pkg::WDOG_TIMEOUT_RC
) (
  // Clock and power-on reset
  input wire logic core_clk,
  input wire logic rst,
  // Option strap, static after power-up
  input wire logic perm_wdog_opt,
  // Core requests, one-cycle pulses
  input wire logic wdog_refresh,
  input wire logic halt_req,
  input wire logic stop_req,
  input wire logic standby_req,
  // Recovery pin, asynchronous
  input wire logic recover_pin,
  // Clock gates
  output logic cpu_clk_en_ff,
  output logic timer_clk_en_ff,
  output logic osc_en_ff,
  output logic wdog_clk_en_ff,
  // Core restart control
  output logic core_hold_ff,
  output logic regs_default_ff,
  output logic [15:0] fetch_addr_ff,
  output logic flag_hold_ff,
  // Status
  output logic wdog_enabled_ff,
  output logic [1:0] reset_cause_ff,
  output var sysctl_pkg::power_state_t state_ff
);
  import sysctl_pkg::*;

  localparam logic [HOLD_W-1:0] HOLD_LAST = HOLD_W'(RESET_HOLD_CYC - 1);
  localparam logic [RC_W-1:0] RC_LAST = RC_W'(RC_DIV_CYC - 1);
  wdog_if wbus();
  logic recover_lvl;
  logic recover_q_ff;
  logic recover_evt;
  logic perm_opt_ff;
  logic strap_done_ff;
  logic [RC_W-1:0] rc_cnt_ff;
  logic rc_tick_ff;
  logic [HOLD_W-1:0] hold_cnt_ff;
  power_state_t nxt_state;
  logic [3:0] nxt_gates;
  logic nxt_wdog_en;
  logic refresh_ok;
  logic wdog_bite;
  logic hold_done;
  logic nxt_hold;

  ////////////////////////////////////////////////////////////////////////////
  // Recovery pin and option strap

  // Pin crosses in from outside the clock domain
  pin_sync3 u_recover_sync (
    .core_clk(core_clk),
    .rst(rst),
    .pin_in(recover_pin),
    .level_ff(recover_lvl)
  );

  // Rising edge of the cleaned level wakes a sleeping device
  always_ff @(posedge core_clk or posedge rst)
  begin
    if (rst)
      recover_q_ff <= 1'b0;
    else
      recover_q_ff <= recover_lvl;
  end

  assign recover_evt = recover_lvl & ~recover_q_ff;
  // Strap caught on the first edge after release, never under reset
  always_ff @(posedge core_clk or posedge rst)
  begin
    if (rst)
    begin
      strap_done_ff <= 1'b0;
      perm_opt_ff <= 1'b0;
    end
    else if (!strap_done_ff)
    begin
      strap_done_ff <= 1'b1;
      perm_opt_ff <= perm_wdog_opt;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Watchdog oscillator and counter

  // Stand-in for the RC oscillator; independent of the mode gates
  always_ff @(posedge core_clk or posedge rst)
  begin
    if (rst)
    begin
      rc_cnt_ff <= '0;
      rc_tick_ff <= 1'b0;
    end
    else if (rc_cnt_ff == RC_LAST)
    begin
      rc_cnt_ff <= '0;
      rc_tick_ff <= 1'b1;
    end
    else
    begin
      rc_cnt_ff <= rc_cnt_ff + 1'b1;
      rc_tick_ff <= 1'b0;
    end
  end

  // Refresh only counts while the core really runs
  assign refresh_ok = wdog_refresh && (state_ff == ST_RUN);
  // A time-out can land in the first cycle after run mode is left; guard drops it
  assign wdog_bite = wbus.timeout && (state_ff == ST_RUN);

  assign wbus.tick = rc_tick_ff;
  assign wbus.enable = wdog_enabled_ff;
  assign wbus.run = (state_ff == ST_RUN);
  assign wbus.refresh = refresh_ok;

  wdog_counter #(
    .TIMEOUT(WDOG_TIMEOUT)
  ) u_wdog (
    .core_clk(core_clk),
    .rst(rst),
    .bus(wbus)
  );

  // Enable is sticky; only a bite or power-on clears it
  always_comb
  begin
    nxt_wdog_en = wdog_enabled_ff;
    if (wdog_bite)
      nxt_wdog_en = 1'b0;
    else if (strap_done_ff && perm_opt_ff)
      nxt_wdog_en = 1'b1;
    else if (refresh_ok)
      nxt_wdog_en = 1'b1;
  end

  always_ff @(posedge core_clk or posedge rst)
  begin
    if (rst)
      wdog_enabled_ff <= 1'b0;
    else
      wdog_enabled_ff <= nxt_wdog_en;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Operating mode sequencer

  assign hold_done = (hold_cnt_ff == HOLD_LAST);
  // Requests are taken at once: the core has flushed beforehand
  always_comb
  begin
    nxt_state = state_ff;
    case (state_ff)
      ST_RESET, ST_RECOVER:
        if (hold_done)
          nxt_state = ST_RUN;
      ST_RUN:
        if (wdog_bite)
          nxt_state = ST_RESET;
        else if (stop_req)
          nxt_state = ST_STOP;
        else if (halt_req)
          nxt_state = ST_HALT;
        else if (standby_req)
          nxt_state = ST_STANDBY;
      ST_HALT, ST_STOP, ST_STANDBY:
        if (recover_evt)
          nxt_state = ST_RECOVER;
      default:
        nxt_state = ST_RESET;
    endcase
  end

  always_ff @(posedge core_clk or posedge rst)
  begin
    if (rst)
      state_ff <= ST_RESET;
    else
      state_ff <= nxt_state;
  end

  // Restart hold length, counted afresh on each entry
  always_ff @(posedge core_clk or posedge rst)
  begin
    if (rst)
      hold_cnt_ff <= '0;
    else if (nxt_state != state_ff)
      hold_cnt_ff <= '0;
    else if (!hold_done)
      hold_cnt_ff <= hold_cnt_ff + 1'b1;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Clock gates and restart outputs

  // Gates register the next state so they line up with state_ff
  assign nxt_gates = mode_gates(nxt_state);
  assign nxt_hold = (nxt_state == ST_RESET) || (nxt_state == ST_RECOVER);

  always_ff @(posedge core_clk or posedge rst)
  begin
    if (rst)
    begin
      cpu_clk_en_ff <= 1'b0;
      timer_clk_en_ff <= 1'b1;
      osc_en_ff <= 1'b1;
      wdog_clk_en_ff <= 1'b0;
    end
    else
    begin
      cpu_clk_en_ff <= nxt_gates[GATE_CPU];
      timer_clk_en_ff <= nxt_gates[GATE_TIMER];
      osc_en_ff <= nxt_gates[GATE_OSC];
      wdog_clk_en_ff <= nxt_gates[GATE_WDOG] && nxt_wdog_en;
    end
  end

  // Defaults load only for power-on or bite; recovery keeps them
  // General-purpose storage has no reset path from here at all
  always_ff @(posedge core_clk or posedge rst)
  begin
    if (rst)
    begin
      core_hold_ff <= 1'b1;
      regs_default_ff <= 1'b1;
    end
    else
    begin
      core_hold_ff <= nxt_hold;
      regs_default_ff <= (nxt_state == ST_RESET);
    end
  end

  // Fetch address presented for every restart
  always_ff @(posedge core_clk or posedge rst)
  begin
    if (rst)
      fetch_addr_ff <= RESET_VECTOR;
    else if (nxt_hold)
      fetch_addr_ff <= RESET_VECTOR;
  end

  // Tells the core to keep zero, sign and overflow on a refresh
  always_ff @(posedge core_clk or posedge rst)
  begin
    if (rst)
      flag_hold_ff <= 1'b0;
    else
      flag_hold_ff <= refresh_ok;
  end

  // Cause of the latest full reset; recovery leaves it alone
  always_ff @(posedge core_clk or posedge rst)
  begin
    if (rst)
      reset_cause_ff <= CAUSE_POR;
    else if (wdog_bite)
      reset_cause_ff <= CAUSE_WDOG;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Checks

  a_bite_resets: assert property (
    @(posedge core_clk) disable iff (rst)
    wdog_bite |=> (state_ff == ST_RESET) && regs_default_ff && core_hold_ff
      && !wdog_enabled_ff && (reset_cause_ff == CAUSE_WDOG))
    else $error("bite did not give a power-on style reset");
  a_recover_keeps: assert property (
    @(posedge core_clk) disable iff (rst)
    (state_ff == ST_RECOVER) |-> core_hold_ff && !regs_default_ff)
    else $error("recovery loaded register defaults");
  a_fetch_vector: assert property (
    @(posedge core_clk) disable iff (rst)
    $fell(core_hold_ff) |-> (fetch_addr_ff == RESET_VECTOR) && cpu_clk_en_ff)
    else $error("restart fetch address wrong");
  a_perm_start: assert property (
    @(posedge core_clk) disable iff (rst)
    (strap_done_ff && perm_opt_ff && !wdog_bite) |=> wdog_enabled_ff)
    else $error("permanent watchdog not running");
  a_idle_no_refresh: assert property (
    @(posedge core_clk) disable iff (rst)
    (!perm_opt_ff && !wdog_enabled_ff && !refresh_ok) |=> !wdog_enabled_ff)
    else $error("watchdog enabled without refresh");
  a_no_disable: assert property (
    @(posedge core_clk) disable iff (rst)
    (wdog_enabled_ff && !wdog_bite) |=> wdog_enabled_ff)
    else $error("enabled watchdog was disabled");
  a_flags_kept: assert property (
    @(posedge core_clk) disable iff (rst)
    refresh_ok |=> flag_hold_ff)
    else $error("flag hold missing on refresh");
  a_halt_gates: assert property (
    @(posedge core_clk) disable iff (rst)
    (state_ff == ST_HALT) |-> !cpu_clk_en_ff && timer_clk_en_ff && osc_en_ff
      && !wdog_clk_en_ff)
    else $error("halt clock gates wrong");
  a_stop_gates: assert property (
    @(posedge core_clk) disable iff (rst)
    ((state_ff == ST_STOP) || (state_ff == ST_STANDBY)) |-> !cpu_clk_en_ff
      && !timer_clk_en_ff && !osc_en_ff && !wdog_clk_en_ff)
    else $error("stop or standby clock gates wrong");
  a_run_gates: assert property (
    @(posedge core_clk) disable iff (rst)
    (state_ff == ST_RUN) |-> cpu_clk_en_ff && timer_clk_en_ff && osc_en_ff
      && (wdog_clk_en_ff == wdog_enabled_ff))
    else $error("run clock gates wrong");
  a_hold_length: assert property (
    @(posedge core_clk) disable iff (rst)
    $rose(core_hold_ff) |-> core_hold_ff [*8] ##1 !core_hold_ff)
    else $error("restart hold length wrong");
endmodule : sysctl_top
`default_nettype wire

// *** wdog_counter.sv ***
// Watchdog time-out counter driven by the RC tick
`timescale 1ns/100ps
`default_nettype none
module wdog_counter #(
  parameter int TIMEOUT = sysctl_pkg::WDOG_TIMEOUT_RC
) (
  // Clock and reset
  input wire logic core_clk,
  input wire logic rst,
  // Control from the sequencer
  wdog_if.cnt bus
);
  import sysctl_pkg::*;

  localparam int CW = $clog2(TIMEOUT + 1);
  localparam logic [CW-1:0] LAST = CW'(TIMEOUT - 1);

  logic [CW-1:0] count_ff;
  logic timeout_ff;

  assign bus.timeout = timeout_ff;

  // Fixed length; software has no way to change it
  always_ff @(posedge core_clk or posedge rst)
  begin
    if (rst)
    begin
      count_ff <= '0;
      timeout_ff <= 1'b0;
    end
    else
    begin
      timeout_ff <= 1'b0;
      if (bus.refresh || !bus.enable)
        count_ff <= '0;
      else if (bus.run && bus.tick)
      begin
        if (count_ff == LAST)
        begin
          count_ff <= '0;
          timeout_ff <= 1'b1;
        end
        else
          count_ff <= count_ff + 1'b1;
      end
    end
  end

  a_refresh_clears: assert property (
    @(posedge core_clk) disable iff (rst)
    bus.refresh |=> (count_ff == '0) && !timeout_ff)
    else $error("refresh did not clear the watchdog count");

  a_halt_frozen: assert property (
    @(posedge core_clk) disable iff (rst)
    (!bus.run && !bus.refresh && bus.enable) |=> $stable(count_ff) && !timeout_ff)
    else $error("watchdog moved outside run mode");

  a_timeout_at_end: assert property (
    @(posedge core_clk) disable iff (rst)
    $rose(timeout_ff) |-> $past(count_ff) == LAST)
    else $error("time-out fired before the full count");
endmodule : wdog_counter
`default_nettype wire

// *** wdog_if.sv ***
// Carrier between the sequencer and its watchdog counter
`timescale 1ns/100ps
`default_nettype none
interface wdog_if;
  logic tick;
  logic enable;
  logic run;
  logic refresh;
  logic timeout;
  modport ctrl (output tick, output enable, output run, output refresh, input timeout);
  modport cnt (input tick, input enable, input run, input refresh, output timeout);
endinterface : wdog_if
`default_nettype wire
